/* fractional_divider_spread_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Ratio held as integer plus residue over denominator.
// - Bank switches take effect glitch free.
// - Spread only on fractional dividers, two active.
// - Steps per quarter set modulation quarter length.
// - Spread enable alone may change on the selected bank while active.
// - Spread needs enable and valid mode.
// - Writing 0x01 to address 0x06 enters READY.
// - Writing 0x02 to address 0x06 enters ACTIVE.
// - Two dividers, each with banks A and B.
// - Configuration select bit picks bank A or B.
// - Integer bank select bit is only registered and reported; the integer part follows the configuration select.
module fractional_divider_spread_ctrl
   import frac_div_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   // Byte write to the system control location.
   input  wire logic                  sys_wr,
   input  wire logic [7:0]            sys_addr,
   input  wire logic [7:0]            sys_wdata,
   // Bank configuration write: divider, bank, and all fields at once.
   input  wire logic                  cfg_wr,
   input  wire logic                  cfg_div,
   input  wire logic                  cfg_bank,
   input  wire logic [INTG_W-1:0]     cfg_intg,
   input  wire logic [FRAC_W-1:0]     cfg_res,
   input  wire logic [FRAC_W-1:0]     cfg_den,
   input  wire logic [1:0]            cfg_ss_mode,
   input  wire logic [CLKN_W-1:0]     cfg_ss_clk_num,
   input  wire logic [STEP_W-1:0]     cfg_ss_step_num,
   input  wire logic [FRAC_W-1:0]     cfg_ss_step_res,
   // Spread enables, one per divider and bank, live at any time.
   input  wire logic [3:0]            ss_ena,
   // Per-divider bank selects.
   input  wire logic [1:0]            cfg_sel,
   input  wire logic [1:0]            int_div_sel,
   // Output divide pulse per divider (one per output clock).
   input  wire logic [1:0]            out_tick,
   output logic      [1:0]            system_state_control,
   output logic      [1:0]            outputs_on,
   output logic      [1:0]            cfg_sel_applied,
   output logic      [1:0]            int_sel_applied,
   output logic      [2*INTG_W-1:0]   ratio_intg,
   output logic      [2*FRAC_W-1:0]   ratio_res,
   output logic      [2*FRAC_W-1:0]   ratio_den,
   output logic      [1:0]            ss_active,
   output logic      [1:0]            cfg_rejected
);

   // Bank storage indexed by {divider, bank}.
   logic [INTG_W-1:0] intg     [4];  // Integer part of ratio.
   logic [FRAC_W-1:0] res      [4];  // Residue numerator.
   logic [FRAC_W-1:0] den      [4];  // Denominator.
   ss_mode_t          mode     [4];  // Spread mode.
   logic [CLKN_W-1:0] clk_num  [4];  // Output clocks per step.
   logic [STEP_W-1:0] step_num [4];  // Steps per quarter.
   logic [FRAC_W-1:0] step_res [4];  // Step size numerator.
   sys_state_t        state;         // Device state.
   sys_state_t        next_state;

   // Index of the bank currently driving divider d.
   function automatic logic [1:0] live_idx(input logic d, input logic sel);
      live_idx = {d, sel};
   endfunction

   // System state: commands only decoded at the control address.
   always_comb begin
      next_state = state;
      if (sys_wr && sys_addr == SYS_CTRL_ADDR) begin
         if (sys_wdata == SYS_CMD_READY) begin
            next_state = ST_READY;
         end else if (sys_wdata == SYS_CMD_ACTIVE) begin
            next_state = ST_ACTIVE;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state <= ST_RESET;
      end else begin
         state <= next_state;
      end
   end

   // Configuration write is refused on the bank that is live while active.
   logic cfg_ok;
   assign cfg_ok = cfg_wr && !(state == ST_ACTIVE && cfg_sel_applied[cfg_div] == cfg_bank);

   // Bank registers: one write port, four independent sets.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int i = 0; i < 4; i++) begin
            intg[i]     <= INTG_RESET;
            res[i]      <= '0;
            den[i]      <= DEN_RESET;
            mode[i]     <= SS_OFF;
            clk_num[i]  <= CLKN_RESET;
            step_num[i] <= '0;
            step_res[i] <= '0;
         end
      end else if (cfg_ok) begin
         intg[{cfg_div, cfg_bank}]     <= cfg_intg;
         res[{cfg_div, cfg_bank}]      <= cfg_res;
         den[{cfg_div, cfg_bank}]      <= cfg_den;
         mode[{cfg_div, cfg_bank}]     <= ss_mode_t'(cfg_ss_mode);
         clk_num[{cfg_div, cfg_bank}]  <= cfg_ss_clk_num;
         step_num[{cfg_div, cfg_bank}] <= cfg_ss_step_num;
         step_res[{cfg_div, cfg_bank}] <= cfg_ss_step_res;
      end
   end

   // Per-divider modulation engine.
   generate
      for (genvar d = 0; d < 2; d++) begin : g_div
         logic [1:0]        li;        // Live bank index.
         logic              sel_q;     // Applied config select.
         logic              isel_q;    // Applied integer select.
         logic              next_sel;
         logic              next_isel;
         logic [CLKN_W-1:0] clk_cnt;   // Clocks within a step.
         logic [STEP_W-1:0] step_cnt;  // Steps within a quarter.
         logic [1:0]        quarter;   // Quarter of the period.
         logic [STEP_W-1:0] pos;       // Offset in steps from nominal.
         logic [CLKN_W-1:0] next_clk_cnt;
         logic [STEP_W-1:0] next_step_cnt;
         logic [1:0]        next_quarter;
         logic              spreading;
         logic              step_now;
         logic [INTG_W+FRAC_W+STEP_W-1:0] nom_frac;  // Nominal ratio in den units.
         logic [INTG_W+FRAC_W+STEP_W-1:0] delta;     // Offset in den units.
         logic [INTG_W+FRAC_W+STEP_W-1:0] eff;
         logic [INTG_W+FRAC_W+STEP_W-1:0] next_eff;

         assign li = live_idx(1'(d), sel_q);
         // Spread runs only with enable and a valid mode.
         assign spreading = ss_ena[li] && (mode[li] == SS_CENTER || mode[li] == SS_DOWN);
         assign step_now = out_tick[d] && (clk_cnt + 8'h01 >= clk_num[li]);

         // Bank selects switch only on an output clock boundary, so the divider
         // never sees a half-applied configuration.
         always_comb begin
            next_sel  = sel_q;
            next_isel = isel_q;
            if (out_tick[d]) begin
               next_sel  = cfg_sel[d];
               next_isel = int_div_sel[d];
            end
         end

         // Step and quarter counters of the triangular profile.
         always_comb begin
            next_clk_cnt  = clk_cnt;
            next_step_cnt = step_cnt;
            next_quarter  = quarter;
            if (!spreading || sel_q != next_sel) begin
               next_clk_cnt  = '0;
               next_step_cnt = '0;
               next_quarter  = 2'b00;
            end else if (out_tick[d]) begin
               next_clk_cnt = step_now ? '0 : clk_cnt + 8'h01;
               if (step_now) begin
                  if (step_cnt + 16'h0001 >= step_num[li]) begin
                     next_step_cnt = '0;
                     next_quarter  = quarter + 2'b01;
                  end else begin
                     next_step_cnt = step_cnt + 16'h0001;
                  end
               end
            end
         end

         // Position: up in quarters 0 and 2, down in 1 and 3; quarters 2 and 3 mirror 0 and 1.
         always_comb begin
            case (quarter)
               2'b00:   pos = step_cnt;
               2'b01:   pos = step_num[li] - step_cnt;
               2'b10:   pos = step_cnt;
               default: pos = step_num[li] - step_cnt;
            endcase
         end

         // Effective ratio numerator over den: nominal plus signed offset.
         always_comb begin
            nom_frac = 47'(intg[li]) * 47'(den[li]) + 47'(res[li]);
            delta    = 47'(pos) * 47'(step_res[li]);
            next_eff = nom_frac;
            if (spreading) begin
               if (mode[li] == SS_DOWN) begin
                  // Lower frequency means a larger ratio, from nominal to the extreme.
                  next_eff = nom_frac + delta + delta;
               end else if (quarter[1]) begin
                  next_eff = nom_frac - delta;
               end else begin
                  next_eff = nom_frac + delta;
               end
            end
         end

         always_ff @(posedge clk) begin
            if (!reset_n) begin
               sel_q    <= 1'b0;
               isel_q   <= 1'b0;
               clk_cnt  <= '0;
               step_cnt <= '0;
               quarter  <= 2'b00;
               eff      <= '0;
            end else begin
               sel_q    <= next_sel;
               isel_q   <= next_isel;
               clk_cnt  <= next_clk_cnt;
               step_cnt <= next_step_cnt;
               quarter  <= next_quarter;
               eff      <= next_eff;
            end
         end

         // Registered outputs; ratio split back into integer and residue.
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               ratio_intg[d*INTG_W +: INTG_W] <= '0;
               ratio_res[d*FRAC_W +: FRAC_W]  <= '0;
               ratio_den[d*FRAC_W +: FRAC_W]  <= '0;
               outputs_on[d]                  <= 1'b0;
               ss_active[d]                   <= 1'b0;
               cfg_sel_applied[d]             <= 1'b0;
               int_sel_applied[d]             <= 1'b0;
               cfg_rejected[d]                <= 1'b0;
            end else begin
               ratio_intg[d*INTG_W +: INTG_W] <= INTG_W'(eff / 47'(den[li] | 15'h0001));
               ratio_res[d*FRAC_W +: FRAC_W]  <= FRAC_W'(eff % 47'(den[li] | 15'h0001));
               ratio_den[d*FRAC_W +: FRAC_W]  <= den[li];
               outputs_on[d]                  <= (state == ST_ACTIVE);
               ss_active[d]                   <= spreading && state == ST_ACTIVE;
               cfg_sel_applied[d]             <= next_sel;
               int_sel_applied[d]             <= next_isel;
               cfg_rejected[d]                <= cfg_wr && !cfg_ok && cfg_div == 1'(d);
            end
         end
      end
   endgenerate

   // State code visible to software.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         system_state_control <= 2'b00;
      end else begin
         system_state_control <= next_state;
      end
   end

   a_ready_cmd: assert property (@(posedge clk) disable iff (!reset_n)
      (sys_wr && sys_addr == SYS_CTRL_ADDR && sys_wdata == SYS_CMD_READY)
      |=> (system_state_control == ST_READY) ##1 (outputs_on == 2'b00))
      else $error("ready command not taken");
   a_active_cmd: assert property (@(posedge clk) disable iff (!reset_n)
      (sys_wr && sys_addr == SYS_CTRL_ADDR && sys_wdata == SYS_CMD_ACTIVE)
      |=> ##1 (outputs_on == 2'b11))
      else $error("active command not taken");
   a_live_refused: assert property (@(posedge clk) disable iff (!reset_n)
      (cfg_wr && state == ST_ACTIVE && cfg_sel_applied[cfg_div] == cfg_bank)
      |=> cfg_rejected != 2'b00)
      else $error("live bank write not refused");
   a_sel_boundary: assert property (@(posedge clk) disable iff (!reset_n)
      (!out_tick[0]) |=> $stable(g_div[0].sel_q))
      else $error("bank switched off a clock boundary");
   a_bad_mode: assert property (@(posedge clk) disable iff (!reset_n)
      (mode[g_div[1].li] == SS_BAD) |-> !g_div[1].spreading)
      else $error("invalid mode spreads");
   a_sel_follow: assert property (@(posedge clk) disable iff (!reset_n)
      (out_tick[1]) |=> (cfg_sel_applied[1] == $past(cfg_sel[1])))
      else $error("config select not applied");
   a_isel_follow: assert property (@(posedge clk) disable iff (!reset_n)
      (out_tick[0]) |=> (int_sel_applied[0] == $past(int_div_sel[0])))
      else $error("integer select not applied");
   a_quarter_turn: assert property (@(posedge clk) disable iff (!reset_n)
      (g_div[1].spreading && g_div[1].sel_q == g_div[1].next_sel && g_div[1].step_now
       && g_div[1].step_cnt + 16'h0001 >= step_num[g_div[1].li])
      |=> g_div[1].quarter == $past(g_div[1].quarter) + 2'b01)
      else $error("quarter did not advance");
   a_down_above: assert property (@(posedge clk) disable iff (!reset_n)
      (g_div[1].spreading && mode[g_div[1].li] == SS_DOWN)
      |-> g_div[1].next_eff >= g_div[1].nom_frac)
      else $error("down spread below nominal");

endmodule

`default_nettype wire

/* frac_div_pkg.sv */
`default_nettype none
package frac_div_pkg;

   // System control codes written to the state control byte.
   localparam logic [7:0] SYS_CMD_READY   = 8'h01;
   localparam logic [7:0] SYS_CMD_ACTIVE  = 8'h02;
   localparam logic [7:0] SYS_CTRL_ADDR   = 8'h06;

   // Field widths of the divider configuration.
   localparam int INTG_W = 16;
   localparam int FRAC_W = 15;
   localparam int STEP_W = 16;
   localparam int CLKN_W = 8;

   // Ratio scale: the integer part is counted in 1/128 units.
   localparam int RATIO_SCALE = 128;

   // Reset values.
   localparam logic [INTG_W-1:0] INTG_RESET = 16'h0800;
   localparam logic [FRAC_W-1:0] DEN_RESET  = 15'h7FFF;
   localparam logic [CLKN_W-1:0] CLKN_RESET = 8'h01;

   // Spread mode encodings.
   typedef enum logic [1:0] {
      SS_OFF    = 2'b00,
      SS_CENTER = 2'b01,
      SS_BAD    = 2'b10,
      SS_DOWN   = 2'b11
   } ss_mode_t;

   // Device operating state.
   typedef enum logic [1:0] {
      ST_RESET  = 2'b00,
      ST_READY  = 2'b01,
      ST_ACTIVE = 2'b10
   } sys_state_t;

endpackage

`default_nettype wire

/* fractional_divider_spread_ctrl_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module fractional_divider_spread_ctrl_tb
   import frac_div_pkg::*;
;
   // Stimulus starts idle; the denominator, clocks per step and step count stay fixed.
   logic                clk, reset_n = 1'b0;
   logic                sys_wr = 1'b0, cfg_wr = 1'b0, cfg_div = 1'b0, cfg_bank = 1'b0;
   logic [7:0]          sys_addr = 8'h00, sys_wdata = 8'h00;
   logic [INTG_W-1:0]   cfg_intg = 16'h0000;
   logic [FRAC_W-1:0]   cfg_res = 15'h0000, cfg_den = 15'h7FFF, cfg_ss_step_res = 15'h0000;
   logic [1:0]          cfg_ss_mode = 2'h0, cfg_sel = 2'h0, int_div_sel = 2'h0, out_tick = 2'h0;
   logic [CLKN_W-1:0]   cfg_ss_clk_num = 8'h01;
   logic [STEP_W-1:0]   cfg_ss_step_num = 16'h0004;
   logic [3:0]          ss_ena = 4'h0;
   logic [1:0]          system_state_control, outputs_on, cfg_sel_applied;
   logic [1:0]          int_sel_applied, ss_active, cfg_rejected;
   logic [2*INTG_W-1:0] ratio_intg;
   logic [2*FRAC_W-1:0] ratio_res, ratio_den;
   // Bench model of the banks and of the selects in effect.
   int                  m_intg[4], m_sel[2];
   int                  v_int, v_res, v_str, v_pct, v_stn = 4;
   int                  err_count = 0, n_checks = 0, cycles = 0;
   bit                  m_act = 1'b0;

   fractional_divider_spread_ctrl uut (
      .clk(clk), .reset_n(reset_n), .sys_wr(sys_wr), .sys_addr(sys_addr),
      .sys_wdata(sys_wdata), .cfg_wr(cfg_wr), .cfg_div(cfg_div), .cfg_bank(cfg_bank),
      .cfg_intg(cfg_intg), .cfg_res(cfg_res), .cfg_den(cfg_den), .cfg_ss_mode(cfg_ss_mode),
      .cfg_ss_clk_num(cfg_ss_clk_num), .cfg_ss_step_num(cfg_ss_step_num),
      .cfg_ss_step_res(cfg_ss_step_res), .ss_ena(ss_ena), .cfg_sel(cfg_sel),
      .int_div_sel(int_div_sel), .out_tick(out_tick),
      .system_state_control(system_state_control), .outputs_on(outputs_on),
      .cfg_sel_applied(cfg_sel_applied), .int_sel_applied(int_sel_applied),
      .ratio_intg(ratio_intg), .ratio_res(ratio_res), .ratio_den(ratio_den),
      .ss_active(ss_active), .cfg_rejected(cfg_rejected));

   // Free running clock of 5 ns.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // A hang is cut short well past the expected run length.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         finish_test();
      end
   end

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task finish_test();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // One system control write; state follows one cycle later, outputs one more.
   task sys_cmd(input logic [7:0] a, input logic [7:0] d, input int st, input int on);
      @(posedge clk);
      sys_wr <= 1'b1;
      sys_addr <= a;
      sys_wdata <= d;
      @(posedge clk);
      sys_wr <= 1'b0;
      @(negedge clk);
      chk("state", st, system_state_control);
      @(negedge clk);
      chk("outputs_on", on, outputs_on);
   endtask

   // Whole bank write with random ratio; the model keeps it unless refused.
   task cfg_write(input int d, input int b, input int md);
      @(posedge clk);
      v_int = 32'h0400 + ($urandom & 32'h0FFF);
      v_res = 32'h2000 + ($urandom & 32'h0FFF);
      v_pct = 64 + ($urandom % 192);
      // Step size from the spread percentage, counted in millionths of a percent so
      // that the short test profile stays well inside the residue range.
      v_str = int'((longint'(md == 1 ? 2 : 1) * v_pct * cfg_den * v_int)
                   / (longint'(100000000) * 2 * v_stn));
      cfg_wr <= 1'b1;
      cfg_div <= d[0];
      cfg_bank <= b[0];
      cfg_intg <= v_int[INTG_W-1:0];
      cfg_res <= v_res[FRAC_W-1:0];
      cfg_ss_mode <= md[1:0];
      cfg_ss_step_res <= v_str[FRAC_W-1:0];
      @(posedge clk);
      cfg_wr <= 1'b0;
      @(negedge clk);
      chk("cfg_rejected", (m_act && b == m_sel[d]) ? 1 << d : 0, cfg_rejected);
      if (!(m_act && b == m_sel[d])) begin
         m_intg[d*2+b] = v_int;
      end
   endtask

   // Switch both selects at an output clock boundary, then compare the ratio.
   task select(input int d, input int b);
      int n;
      @(posedge clk);
      cfg_sel[d] <= b[0];
      int_div_sel[d] <= b[0];
      out_tick[d] <= 1'b1;
      @(posedge clk);
      out_tick[d] <= 1'b0;
      n = 0;
      while (cfg_sel_applied[d] !== b[0] && n < 8) begin
         @(negedge clk);
         n++;
      end
      repeat (3) @(negedge clk);
      m_sel[d] = b;
      chk("cfg_sel", b, cfg_sel_applied[d]);
      chk("int_sel", b, int_sel_applied[d]);
      chk("ratio_intg", m_intg[d*2+b], ratio_intg[d*INTG_W +: INTG_W]);
      chk("ratio_den", DEN_RESET, ratio_den[d*FRAC_W +: FRAC_W]);
   endtask

   // Spread on divider 1 with a tick every clock; the extremes follow the mode.
   task run_spread(input int md);
      int lo, hi, r, s;
      lo = 32'h0000_FFFF;
      hi = 0;
      s = v_stn * v_str;
      @(posedge clk);
      ss_ena <= 4'hF;
      out_tick <= 2'b10;
      repeat (64) begin
         @(negedge clk);
         r = ratio_res[FRAC_W +: FRAC_W];
         if (r < lo) lo = r;
         if (r > hi) hi = r;
      end
      chk("ss_active", (md % 2) << 1, ss_active);
      chk("spread_hi", v_res + (md == 1 ? s : md == 3 ? 2 * s : 0), hi);
      chk("spread_lo", v_res - (md == 1 ? s : 0), lo);
      @(posedge clk);
      ss_ena <= 4'h0;
      out_tick <= 2'b00;
      repeat (4) @(negedge clk);
      chk("ss_active", 0, ss_active);
   endtask

   initial begin
      void'($urandom(80380));
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      chk("state", 0, system_state_control);
      sys_cmd(8'h05, 8'h01, 0, 0);
      sys_cmd(8'h06, 8'h01, 1, 0);
      sys_cmd(8'h06, 8'h07, 1, 0);
      for (int k = 0; k < 4; k++) cfg_write(k / 2, k % 2, 0);
      for (int k = 0; k < 4; k++) select(k / 2, (k + 1) % 2);
      sys_cmd(8'h06, 8'h02, 2, 3);
      m_act = 1'b1;
      cfg_write(0, m_sel[0], 0);
      select(0, m_sel[0]);
      cfg_write(0, 1 - m_sel[0], 0);
      select(0, 1 - m_sel[0]);
      for (int md = 0; md < 4; md++) begin
         cfg_write(1, 1 - m_sel[1], md);
         select(1, 1 - m_sel[1]);
         run_spread(md);
      end
      finish_test();
   end
endmodule
`default_nettype wire
